// ==== verif/host_reader.sv ====
// Host-side model that reads the result bus with chip select and read strobe
`timescale 1ns/1ps
module host_reader (
  input wire logic clk_in,
  input wire logic [11:0] bus_in,
  input wire logic oe_in,
  output logic cs_n_out,
  output logic rd_n_out
);
  // ---------------------------------------------------------------
  // Read cycle
  // ---------------------------------------------------------------
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
  end

  // Strobes held low past the pin synchroniser, then idle so the edge lands
  task automatic read_word(output logic [11:0] data, output logic oe_seen);
    @(negedge clk_in);
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    repeat (5) @(negedge clk_in);
    data = bus_in;
    oe_seen = oe_in;
    rd_n_out = 1'b1;
    cs_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the result read-out block
`timescale 1ns/1ps
module tb_top;
  import readout_pkg::*;
  localparam int TICK = 8;
  logic clk_in, rstn_in, cs_n, rd_n, ext_clk, ext_run, int_sel, bipolar, standby_n, start;
  logic [2:0] chan_count;
  logic [11:0] conv_data, bus_out, last_bus, bus_wire, got;
  logic [11:0] regs [4];
  logic oe, flag, eoc_n, busy, oe_seen;
  logic [31:0] seed, r;
  int err_count, cmp_count, nconv, lo, hi;

  result_readout #(.TICK_CYCLES(TICK)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .ext_clk_in(ext_clk), .int_clk_sel_in(int_sel),
    .bipolar_in(bipolar), .standby_n_in(standby_n), .conv_start_in(start),
    .chan_count_in(chan_count), .conv_data_in(conv_data), .result_bus_out(bus_out),
    .result_bus_oe_out(oe), .first_result_flag_out(flag), .eoc_n_out(eoc_n),
    .busy_out(busy));
  host_reader host (.clk_in(clk_in), .bus_in(bus_wire), .oe_in(oe), .cs_n_out(cs_n),
    .rd_n_out(rd_n));

  // ---------------------------------------------------------------
  // Clocks, bus wire and helpers
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Conversion clock only moves while a frame is wanted
  initial begin
    ext_clk = 1'b0;
    forever begin
      repeat (4) @(negedge clk_in);
      if (ext_run) ext_clk = ~ext_clk;
    end
  end
  // Released bus shows the inverse, so a stale value never passes
  always_ff @(posedge clk_in) if (oe) last_bus <= bus_out;
  assign bus_wire = oe ? bus_out : ~last_bus;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] code(input logic [11:0] d, input logic bip);
    return bip ? {~d[11], d[10:0]} : d;
  endfunction

  // Record each transferred result, then offer a fresh raw value
  always @(negedge eoc_n) begin
    regs[nconv[1:0]] = code(conv_data, bipolar);
    nconv++;
    @(negedge clk_in);
    r = rnd();
    conv_data = r[11:0];
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [11:0] exp);
    host.read_word(got, oe_seen);
    check(got, exp, "read data");
    check({11'h000, oe_seen}, 12'h001, "bus enable");
    check({11'h000, oe}, 12'h000, "bus released");
  endtask
  task automatic start_seq(input logic [2:0] n);
    @(negedge clk_in);
    chan_count = n;
    nconv = 0;
    start = 1'b1;
    @(negedge clk_in);
    start = 1'b0;
    check({11'h000, busy}, 12'h001, "busy after start");
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge clk_in);
    check({11'h000, busy}, 12'h000, "sequence end");
  endtask
  task automatic wait_eoc();
    for (int i = 0; i < 2000 && eoc_n !== 1'b0; i++) @(negedge clk_in);
    check({11'h000, eoc_n}, 12'h000, "end of conversion seen");
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    #160000;
    err_count++;
    wrap_up();
  end

  initial begin
    seed = 32'h0001_6C1B;
    {ext_run, bipolar, start, nconv} = '0;
    {rstn_in, int_sel, standby_n} = 3'b011;
    chan_count = 3'h1;
    conv_data = 12'h000;
    repeat (3) @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    check({11'h000, flag}, 12'h001, "flag after reset");
    check({11'h000, oe}, 12'h000, "bus idle");
    // Each sequence length, read after the end, one extra read wraps
    for (int n = 1; n <= 4; n++) begin
      r = rnd();
      bipolar = (n < 3) ? 1'b1 : r[0];
      standby_n = r[1];
      conv_data = (n == 1) ? 12'hFFF : (n == 2) ? 12'h000 : r[23:12];
      start_seq(3'(n));
      wait_idle();
      check({11'h000, flag}, 12'h001, "flag at register 1");
      check(12'(nconv), 12'(n), "result count");
      for (int k = 0; k <= n; k++) rd_chk(regs[k % n]);
      check({11'h000, flag}, {11'h000, n == 1}, "flag after wrap");
      $display("test sequence of %0d done", n);
    end
    // Reads inside a running sequence
    start_seq(3'h4);
    wait_eoc();
    rd_chk(regs[0]);
    rd_chk(regs[0]);
    wait_eoc();
    @(negedge clk_in);
    check({11'h000, flag}, 12'h000, "flag after second transfer");
    rd_chk(regs[1]);
    wait_idle();
    rd_chk(regs[2]);
    rd_chk(regs[3]);
    rd_chk(regs[0]);
    $display("test reads during sequence done");
    // External conversion clock: 14 clocks per conversion, EOC low one clock
    int_sel = 1'b0;
    ext_run = 1'b1;
    start_seq(3'h2);
    wait_eoc();
    for (lo = 0; lo < 200 && eoc_n === 1'b0; lo++) @(negedge clk_in);
    for (hi = 0; hi < 400 && eoc_n === 1'b1; hi++) @(negedge clk_in);
    check(12'(lo), 12'h008, "eoc low width");
    check(12'(lo + hi), 12'h070, "conversion length");
    wait_idle();
    ext_run = 1'b0;
    int_sel = 1'b1;
    $display("test external clock done");
    wrap_up();
  end
endmodule

// ==== verilog/conv_seq_timer.sv ====
// Conversion sequence timer: counts conversion clocks and marks transfers
`timescale 1ns/1ps
module conv_seq_timer
  import readout_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic tick_in,
  input wire logic [2:0] chan_count_in,
  output logic busy_out,
  output logic ptr_reset_out,
  output logic xfer_out,
  output logic eoc_n_out,
  output logic [1:0] conv_idx_out
);

  seq_state_type state_r;
  logic [3:0] clk_cnt_r;
  logic [1:0] last_idx_r;
  logic last_clock;
  logic eoc_end_r;

  assign last_clock = tick_in && (clk_cnt_r == CONV_CLOCKS - 4'h1);
  assign busy_out = (state_r == SEQ_CONV);

  // ---------------------------------------------------------------
  // Sequence state and clock count
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r <= SEQ_IDLE;
      clk_cnt_r <= CLK_COUNT_RST;
      conv_idx_out <= 2'h0;
      last_idx_r <= 2'h0;
    end else begin
      case (state_r)
        SEQ_IDLE: begin
          if (start_in) begin
            state_r <= SEQ_CONV;
            clk_cnt_r <= CLK_COUNT_RST;
            conv_idx_out <= 2'h0;
            // A zero count is taken as one channel
            last_idx_r <= (chan_count_in == 3'h0) ? 2'h0 : 2'(chan_count_in - 3'h1);
          end
        end
        SEQ_CONV: begin
          if (last_clock) begin
            clk_cnt_r <= CLK_COUNT_RST;
            conv_idx_out <= 2'(conv_idx_out + 2'h1);
            if (conv_idx_out == last_idx_r) begin
              state_r <= SEQ_IDLE;
            end
          end else if (tick_in) begin
            clk_cnt_r <= 4'(clk_cnt_r + 4'h1);
          end
        end
        default: begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pointer reset, transfer and end-of-conversion strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ptr_reset_out <= 1'b0;
      xfer_out <= 1'b0;
      eoc_n_out <= 1'b1;
      eoc_end_r <= 1'b0;
    end else begin
      // Clock 12 of the first conversion only
      ptr_reset_out <= busy_out && tick_in && (conv_idx_out == 2'h0) &&
                       (clk_cnt_r == PTR_RESET_CLOCK - 4'h1); // RULE_12
      xfer_out <= busy_out && tick_in && (clk_cnt_r == XFER_CLOCK - 4'h1); // RULE_12
      // Rise delayed like the fall, so EOC stays low one whole conversion clock
      eoc_end_r <= last_clock;
      if (xfer_out) begin
        eoc_n_out <= 1'b0;
      end else if (eoc_end_r) begin
        eoc_n_out <= 1'b1; // RULE_12
      end
    end
  end

endmodule

// ==== verilog/readout_pkg.sv ====
// Constants and carrier types for the result read-out block
package readout_pkg;

  // ---------------------------------------------------------------
  // Result storage
  // ---------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int NUM_RESULTS = 4;
  localparam logic [1:0] PTR_FIRST = 2'h0;
  localparam logic [2:0] VALID_NONE = 3'h0;
  localparam logic [11:0] RESULT_RST = 12'h000;

  // ---------------------------------------------------------------
  // Conversion clock timing (clocks counted from 1 within a conversion)
  // ---------------------------------------------------------------
  localparam logic [3:0] CONV_CLOCKS = 4'hE;
  localparam logic [3:0] PTR_RESET_CLOCK = 4'hC;
  localparam logic [3:0] XFER_CLOCK = 4'hD;
  localparam logic [3:0] CLK_COUNT_RST = 4'h0;

  // Internal conversion time and system clock rate
  localparam int INT_CONV_TIME_NS = 1650;
  localparam int SYS_CLK_MHZ = 250;
  // Longest time per conversion clock, rounded down, never below one
  localparam int INT_TICK_RAW = (INT_CONV_TIME_NS * SYS_CLK_MHZ) / (1000 * 14);
  localparam int INT_TICK_CYCLES = (INT_TICK_RAW < 1) ? 1 : INT_TICK_RAW;
  localparam logic [7:0] DIV_RST = 8'h00;

  // ---------------------------------------------------------------
  // Carrier for the asynchronous pins
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic ext_clk;
    logic int_clk_sel;
    logic bipolar;
  } pin_bundle_type;

  localparam pin_bundle_type PINS_RST = '{cs_n: 1'b1, rd_n: 1'b1, ext_clk: 1'b0,
                                          int_clk_sel: 1'b1, bipolar: 1'b0};

  // Sequence timer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_CONV = 2'b10
  } seq_state_type;

endpackage

// ==== verilog/result_readout.sv ====
// Result registers, circular read pointer and parallel result bus
//
// Overview of operation
// RULE_01: Four result registers hold a sequence's results, the k-th conversion in register k.
// RULE_02: The first conversion's end sets the pointer to register 1 just before EOC falls.
// RULE_03: Setting the pointer to register 1 raises the first-result flag.
// RULE_04: The addressed register drives the result bus only while chip select and read are low.
// RULE_05: After the sequence ends, each read-strobe rising edge advances the pointer.
// RULE_06: During a sequence a read does not advance onto a register not yet holding a result.
// RULE_07: During a sequence each result transfer advances the pointer just before EOC falls; the code advances it only when a read is pending.
// RULE_08: The read-strobe rising edge after reading the last result wraps the pointer to 1.
// RULE_09: Bipolar ranges give two's complement results with 0x7FF and 0x800 as full scales.
// RULE_10: Reads during a conversion keep returning the current register until it advances.
// RULE_11: The first-result flag falls when the pointer leaves register 1.
// RULE_12: A conversion takes 14 clocks: pointer reset on 12, transfer and EOC on 13 and 14.
// RULE_13: Results and the bus read path stay usable while standby is asserted.
// RULE_14: The pointer wraps at the number of channels selected for the sequence.
// RULE_15: With no chip select and read active the result bus is not driven.
`timescale 1ns/1ps
module result_readout
  import readout_pkg::*;
#(
  parameter int TICK_CYCLES = INT_TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic ext_clk_in,
  input wire logic int_clk_sel_in,
  input wire logic bipolar_in,
  input wire logic standby_n_in,
  input wire logic conv_start_in,
  input wire logic [2:0] chan_count_in,
  input wire logic [11:0] conv_data_in,
  output logic [11:0] result_bus_out,
  output logic result_bus_oe_out,
  output logic first_result_flag_out,
  output logic eoc_n_out,
  output logic busy_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pin_bundle_type pins_in;
  pin_bundle_type pins_s1_r;
  pin_bundle_type pins_s2_r;
  logic rd_prev_r;
  logic cs_prev_r;
  logic ext_prev_r;

  assign pins_in = '{cs_n: cs_n_in, rd_n: rd_n_in, ext_clk: ext_clk_in,
                     int_clk_sel: int_clk_sel_in, bipolar: bipolar_in};

  // Only the second stage and the edge history are read by logic
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pins_s1_r <= PINS_RST;
      pins_s2_r <= PINS_RST;
      rd_prev_r <= 1'b1;
      cs_prev_r <= 1'b1;
      ext_prev_r <= 1'b0;
    end else begin
      pins_s1_r <= pins_in;
      pins_s2_r <= pins_s1_r;
      rd_prev_r <= pins_s2_r.rd_n;
      cs_prev_r <= pins_s2_r.cs_n;
      ext_prev_r <= pins_s2_r.ext_clk;
    end
  end

  // A read ends on the read rising edge of a selected access
  logic rd_rise;
  assign rd_rise = pins_s2_r.rd_n && !rd_prev_r && !cs_prev_r;

  // ---------------------------------------------------------------
  // Conversion clock: internal divider or falling edge of the pin
  // ---------------------------------------------------------------
  logic [7:0] div_r;
  logic int_tick;
  logic conv_tick;

  assign int_tick = (div_r == 8'(TICK_CYCLES - 1));
  assign conv_tick = pins_s2_r.int_clk_sel ? int_tick : (ext_prev_r && !pins_s2_r.ext_clk);

  always_ff @(posedge clk_in) begin
    if (!rstn_in || int_tick) begin
      div_r <= DIV_RST;
    end else begin
      div_r <= 8'(div_r + 8'h01);
    end
  end

  // ---------------------------------------------------------------
  // Sequence timer
  // ---------------------------------------------------------------
  logic ptr_reset;
  logic xfer;
  logic [1:0] conv_idx;

  conv_seq_timer u_timer (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(conv_start_in),
    .tick_in(conv_tick),
    .chan_count_in(chan_count_in),
    .busy_out(busy_out),
    .ptr_reset_out(ptr_reset),
    .xfer_out(xfer),
    .eoc_n_out(eoc_n_out),
    .conv_idx_out(conv_idx)
  );

  // ---------------------------------------------------------------
  // Result registers and coding
  // ---------------------------------------------------------------
  logic [RESULT_W-1:0] res_r [NUM_RESULTS];
  logic [RESULT_W-1:0] coded;
  logic [2:0] valid_cnt_r;
  logic [1:0] last_idx_r;

  // Offset binary flipped at the sign bit gives two's complement
  assign coded = pins_s2_r.bipolar ? {~conv_data_in[11], conv_data_in[10:0]}
                                   : conv_data_in; // RULE_09

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_RESULTS; i++) begin
        res_r[i] <= RESULT_RST;
      end
    end else if (xfer) begin
      res_r[conv_idx] <= coded; // RULE_01
    end
  end

  // Count of results that are valid in the running sequence
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      valid_cnt_r <= VALID_NONE;
      last_idx_r <= 2'h0;
    end else if (conv_start_in && !busy_out) begin
      valid_cnt_r <= VALID_NONE;
      // Wrap point follows the selected channel count
      last_idx_r <= (chan_count_in == 3'h0) ? 2'h0 : 2'(chan_count_in - 3'h1); // RULE_14
    end else if (xfer) begin
      valid_cnt_r <= 3'(valid_cnt_r + 3'h1);
    end
  end

  // ---------------------------------------------------------------
  // Read pointer
  // ---------------------------------------------------------------
  logic [1:0] ptr_r;
  logic [1:0] ptr_nxt;
  logic rd_pend_r;
  logic rd_pend_nxt;

  // Conversion events outrank a read edge in the same cycle; a refused read
  // stays pending so the next transfer serves it, an unread transfer leaves the pointer
  always_comb begin
    ptr_nxt = ptr_r;
    rd_pend_nxt = rd_pend_r;
    if (ptr_reset) begin
      ptr_nxt = PTR_FIRST; // RULE_02
      rd_pend_nxt = 1'b0;
    end else if (xfer && rd_pend_r && conv_idx != 2'h0 && ptr_r == 2'(conv_idx - 2'h1)) begin
      ptr_nxt = conv_idx; // RULE_07
      rd_pend_nxt = 1'b0;
    end else if (rd_rise && !busy_out) begin
      ptr_nxt = (ptr_r == last_idx_r) ? PTR_FIRST : 2'(ptr_r + 2'h1); // RULE_05 RULE_08 RULE_14
      rd_pend_nxt = 1'b0;
    end else if (rd_rise && 3'(ptr_r) + 3'h1 < valid_cnt_r) begin
      ptr_nxt = 2'(ptr_r + 2'h1); // RULE_06 RULE_10
    end else if (rd_rise) begin
      rd_pend_nxt = 1'b1; // RULE_06
    end
  end

  // Pending read, set by a refused read edge and cleared once served
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_pend_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ptr_r <= PTR_FIRST;
      first_result_flag_out <= 1'b1;
    end else begin
      ptr_r <= ptr_nxt;
      first_result_flag_out <= (ptr_nxt == PTR_FIRST); // RULE_03 RULE_11
    end
  end

  // ---------------------------------------------------------------
  // Result bus, independent of standby
  // ---------------------------------------------------------------
  logic bus_sel;
  assign bus_sel = !pins_s2_r.cs_n && !pins_s2_r.rd_n;
  assign result_bus_oe_out = bus_sel; // RULE_04 RULE_15 RULE_13

  // Data stays registered so the bus never glitches with the pointer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      result_bus_out <= RESULT_RST;
    end else begin
      result_bus_out <= res_r[ptr_r]; // RULE_04 RULE_10
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  logic [1:0] xfer_idx_q;
  logic [11:0] xfer_raw_q;
  always_ff @(posedge clk_in) begin
    xfer_idx_q <= conv_idx;
    xfer_raw_q <= conv_data_in;
  end

  ptr_reset_first_a: assert property ( // RULE_02
      ptr_reset |=> ##1 first_result_flag_out && ptr_r == 2'h0)
    else $error("pointer reset did not raise first flag");
  xfer_store_a: assert property (xfer |=> res_r[xfer_idx_q][10:0] == xfer_raw_q[10:0]) // RULE_01
    else $error("result not stored in its register");
  bipolar_code_a: assert property ( // RULE_09
      xfer && pins_s2_r.bipolar |=> res_r[xfer_idx_q][11] != xfer_raw_q[11])
    else $error("bipolar sign bit not inverted");
  bus_drive_a: assert property ( // RULE_04
      result_bus_oe_out == (!$past(cs_n_in, 2) && !$past(rd_n_in, 2)))
    else $error("bus enable does not follow select and read");
  idle_bus_a: assert property (pins_s2_r.cs_n |-> !result_bus_oe_out) // RULE_15
    else $error("bus driven without select");
  rd_advance_a: assert property ( // RULE_05
      rd_rise && !busy_out && !ptr_reset && !xfer && ptr_r != last_idx_r
      |=> ptr_r == 2'($past(ptr_r) + 2'h1))
    else $error("read edge did not advance pointer");
  rd_wrap_a: assert property ( // RULE_08
      rd_rise && !busy_out && !ptr_reset && !xfer && ptr_r == last_idx_r
      |=> ptr_r == 2'h0 ##1 first_result_flag_out)
    else $error("pointer did not wrap after last result");
  rd_hold_a: assert property ( // RULE_06
      rd_rise && busy_out && !ptr_reset && !xfer && 3'(ptr_r) + 3'h1 >= valid_cnt_r
      |=> $stable(ptr_r))
    else $error("pointer advanced onto an empty register");
  xfer_advance_a: assert property ( // RULE_07
      xfer && rd_pend_r && conv_idx != 2'h0 && ptr_r == 2'(conv_idx - 2'h1)
      |=> ptr_r == $past(conv_idx) ##1 !first_result_flag_out)
    else $error("transfer did not advance pointer");
  xfer_no_pend_a: assert property ( // RULE_07
      xfer && !rd_pend_r && !ptr_reset && !rd_rise |=> $stable(ptr_r))
    else $error("transfer moved pointer with no read pending");
  eoc_after_xfer_a: assert property (xfer |=> !eoc_n_out) // RULE_12
    else $error("end of conversion did not fall after transfer");
  flag_tracks_ptr_a: assert property (first_result_flag_out == (ptr_r == 2'h0)) // RULE_11
    else $error("first flag disagrees with pointer");
  wrap_bound_a: assert property (!busy_out |-> ptr_r <= last_idx_r) // RULE_14
    else $error("pointer beyond selected channels");

  wrap_seen_c: cover property (rd_rise && !busy_out && ptr_r == last_idx_r);
  read_held_c: cover property (rd_rise && busy_out && 3'(ptr_r) + 3'h1 >= valid_cnt_r);
  four_chan_c: cover property (xfer && conv_idx == 2'h3);
  standby_read_c: cover property (!standby_n_in && result_bus_oe_out);

endmodule
